//--- spp_pkg.sv
// spp_pkg: shared constants for the serial status and protection block.
// Assumes a 100 MHz core clock and a serial link clocked by its host.
package spp_pkg;

  // opcodes, bit 3 is don't-care
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;

  // status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_LVL0 = 2;
  localparam int ST_LVL1 = 3;
  localparam int ST_HPE  = 7;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] STATUS_BUSY = 8'hFF;

  // protected range starts
  localparam logic [7:0] PROT_QTR_BASE  = 8'hC0;
  localparam logic [7:0] PROT_HALF_BASE = 8'h80;

  // serial framing
  localparam int FRAME_OPC_BITS = 8;
  localparam int FRAME_WR_BITS  = 16;

  // self-timed write cycle
  localparam int CLK_MHZ       = 100;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES_DFLT = WRITE_TIME_US * CLK_MHZ;
  localparam int TMR_W = 20;

endpackage : spp_pkg

//--- spp_link_if.sv
// spp_link_if: words passed between the serial side and the core.
// Assumes each side synchronises the toggles it receives.
`timescale 1ns/100ps
interface spp_link_if;
  logic        post_tgl;
  logic [15:0] post_word;
  logic        stat_tgl;
  logic [7:0]  stat_word;
  logic        stat_ack;

  modport link (output post_tgl, output post_word, output stat_ack,
                input stat_tgl, input stat_word);
  modport core (input post_tgl, input post_word, input stat_ack,
                output stat_tgl, output stat_word);
endinterface : spp_link_if

//--- spp_link.sv
// spp_link: serial shifter on the link clock, suspend handling, data out.
// Assumes mode 0 or 3 framing and a host that keeps suspend steady at edges.
`timescale 1ns/100ps
module spp_link (
  // link clock and reset
  input  wire logic sck,
  input  wire logic resetn,
  // serial pins
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  output logic      so,
  output logic      so_oe,
  // toward the core
  spp_link_if.link  lk
);
  import spp_pkg::*;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic        rd_stat;
    logic        post_tgl;
    logic [15:0] post_word;
    logic [2:0]  ssync;
    logic        ack;
    logic [7:0]  copy;
    logic [7:0]  outb;
  } spp_link_s;

  spp_link_s  q;
  spp_link_s  d;
  logic       start_q;
  logic       so_q;
  logic [4:0] base;

  // ***********************************************
  // frame start marker
  // ***********************************************
  always_ff @(posedge sck or posedge cs_n or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b1;
    end else if (cs_n) begin
      start_q <= 1'b1;
    end else if (hold_n) begin
      start_q <= 1'b0;
    end
  end

  // ***********************************************
  // shifter and status copy
  // ***********************************************
  always_comb begin
    d = q;
    base = start_q ? 5'd0 : q.cnt;
    // suspend freezes every bit of the frame
    if (hold_n) begin
      d.sh  = {q.sh[14:0], si};
      d.cnt = (base == 5'd31) ? 5'd16 : base + 5'd1;
      if (start_q) begin
        d.rd_stat = 1'b0;
      end
      if (d.cnt == 5'(FRAME_OPC_BITS)) begin
        if ((d.sh[7:0] & OP_MASK) == OP_RD_STATUS) begin
          d.rd_stat = 1'b1;
        end
        if ((d.sh[7:0] & OP_MASK) != OP_WR_STATUS) begin
          d.post_word = {d.sh[7:0], 8'h00};
          d.post_tgl  = ~q.post_tgl;
        end
      end
      if (base == 5'(FRAME_WR_BITS - 1) &&
          (d.sh[15:8] & OP_MASK) == OP_WR_STATUS) begin
        d.post_word = d.sh;
        d.post_tgl  = ~q.post_tgl;
      end
      // status repeats byte after byte
      if (d.cnt[2:0] == 3'd0 && d.cnt >= 5'(FRAME_OPC_BITS)) begin
        d.outb = q.copy;
      end
    end
    d.ssync = {q.ssync[1:0], lk.stat_tgl};
    if (q.ssync[2] == q.ssync[1] && q.ssync[1] != q.ack) begin
      d.copy = lk.stat_word;
      d.ack  = q.ssync[1];
    end
  end

  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // data out changes on the falling edge
  always_ff @(negedge sck or negedge resetn) begin
    if (!resetn) begin
      so_q <= 1'b0;
    end else if (q.rd_stat && hold_n) begin
      so_q <= q.outb[~q.cnt[2:0]];
    end
  end

  assign so           = so_q;
  assign so_oe        = !cs_n && hold_n && q.rd_stat && !start_q;
  assign lk.post_tgl  = q.post_tgl;
  assign lk.post_word = q.post_word;
  assign lk.stat_ack  = q.ack;

  // ***********************************************
  // checks
  // ***********************************************
  AST_HOLD_FREEZE: assert property (
    @(posedge sck) disable iff (!resetn)
    (!hold_n && !cs_n) |=> $stable(q.cnt) && $stable(q.sh))
    else $error("serial state moved during suspend");

endmodule : spp_link

//--- spp_status_protect.sv
// spp_status_protect: status byte, write latch and write protection core.
// Assumes array sequencing elsewhere asks for each array write on arr_wr_req.
`timescale 1ns/100ps
module spp_status_protect #(
  parameter int WRITE_CYCLES = spp_pkg::WRITE_CYCLES_DFLT
) (
  // core clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // serial link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       hold_n,
  output logic            so,
  output logic            so_oe,
  // protect pin
  input  wire logic       wp_n,
  // array write gate
  input  wire logic       arr_wr_req,
  input  wire logic [7:0] arr_wr_addr,
  output logic            arr_wr_ok,
  // status view
  output logic [7:0]      status_byte,
  output logic            write_busy,
  output logic            hw_protect_active
);
  import spp_pkg::*;

  typedef struct packed {
    logic [2:0]       wp_sync;
    logic             wp_lvl;
    logic [2:0]       cs_sync;
    logic             cs_lvl;
    logic [2:0]       pt_sync;
    logic             pt_seen;
    logic [2:0]       ak_sync;
    logic [15:0]      word;
    logic             pend;
    logic             wel;
    logic [1:0]       bp;
    logic             hpe;
    logic             busy;
    logic [TMR_W-1:0] timer;
    logic             stwr_job;
    logic [1:0]       new_bp;
    logic             new_hpe;
    logic             stat_tgl;
    logic [7:0]       stat_word;
  } spp_core_s;

  // latch, level bits and enable start clear
  localparam spp_core_s CORE_RST = '{wp_sync: 3'b111, wp_lvl: 1'b1,
                                     cs_sync: 3'b111, cs_lvl: 1'b1,
                                     stat_word: STATUS_RST,
                                     default: '0};
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WRITE_CYCLES - 1);

  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2 ** TMR_W) begin : g_chk
    $error("WRITE_CYCLES out of range");
  end

  spp_core_s q;
  spp_core_s d;
  logic      cs_rise;
  logic      exec;
  logic      hw_prot;
  logic      arr_hit;
  logic [7:0] opc;
  logic [7:0] stat_now;

  spp_link_if lk ();

  spp_link u_link (
    .sck    (sck),
    .resetn (resetn),
    .cs_n   (cs_n),
    .si     (si),
    .hold_n (hold_n),
    .so     (so),
    .so_oe  (so_oe),
    .lk     (lk.link)
  );

  // ***********************************************
  // protected range decode
  // ***********************************************
  function automatic logic in_block(input logic [1:0] lvl,
                                    input logic [7:0] a);
    case (lvl)
      2'b01:   in_block = (a >= PROT_QTR_BASE);
      2'b10:   in_block = (a >= PROT_HALF_BASE);
      2'b11:   in_block = 1'b1;
      default: in_block = 1'b0;
    endcase
  endfunction : in_block

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    d        = q;
    cs_rise  = 1'b0;
    hw_prot  = q.hpe && !q.wp_lvl;
    arr_hit  = in_block(q.bp, arr_wr_addr);
    // busy byte hides every field while writing
    stat_now = STATUS_RST;
    stat_now[ST_WEL] = q.wel;
    stat_now[ST_LVL1:ST_LVL0] = q.bp;
    stat_now[ST_HPE] = q.hpe;
    if (q.busy) begin
      stat_now = STATUS_BUSY;
    end

    // pin and toggle synchronisers
    d.wp_sync = {q.wp_sync[1:0], wp_n};
    if (q.wp_sync[2] == q.wp_sync[1]) begin
      d.wp_lvl = q.wp_sync[1];
    end
    d.cs_sync = {q.cs_sync[1:0], cs_n};
    if (q.cs_sync[2] == q.cs_sync[1]) begin
      d.cs_lvl = q.cs_sync[1];
      cs_rise  = q.cs_sync[1] && !q.cs_lvl;
    end
    d.pt_sync = {q.pt_sync[1:0], lk.post_tgl};
    if (q.pt_sync[2] == q.pt_sync[1] && q.pt_sync[1] != q.pt_seen) begin
      d.word    = lk.post_word;
      d.pend    = 1'b1;
      d.pt_seen = q.pt_sync[1];
    end
    d.ak_sync = {q.ak_sync[1:0], lk.stat_ack};

    // commands act when the frame ends
    exec = cs_rise && d.pend;
    opc  = d.word[15:8] & OP_MASK;
    if (exec) begin
      d.pend = 1'b0;
      if (!q.busy) begin
        case (opc)
          OP_SET_LATCH: begin
            d.wel = 1'b1;
          end
          OP_CLR_LATCH: begin
            d.wel = 1'b0;
          end
          OP_WR_STATUS: begin
            // judged on pin and enable as the frame ends
            if (q.wel && !hw_prot) begin
              d.busy     = 1'b1;
              d.timer    = TMR_LOAD;
              d.stwr_job = 1'b1;
              d.new_bp   = d.word[ST_LVL1:ST_LVL0];
              d.new_hpe  = d.word[ST_HPE];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // array write start
    // gate terms repeated here so the output is not read back
    if (arr_wr_req && q.wel && !q.busy && !arr_hit && !exec) begin
      d.busy     = 1'b1;
      d.timer    = TMR_LOAD;
      d.stwr_job = 1'b0;
    end

    // self-timed write cycle
    if (q.busy) begin
      if (q.timer == '0) begin
        d.busy     = 1'b0;
        d.wel      = 1'b0;
        d.stwr_job = 1'b0;
        // status fields change only at completion
        if (q.stwr_job) begin
          d.bp  = q.new_bp;
          d.hpe = q.new_hpe;
        end
      end else begin
        d.timer = q.timer - 1'b1;
      end
    end

    // publish status to the link side
    if (q.ak_sync[2] == q.ak_sync[1] && q.ak_sync[1] == q.stat_tgl &&
        q.stat_word != stat_now) begin
      d.stat_word = stat_now;
      d.stat_tgl  = ~q.stat_tgl;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  // protected block never writable, rest needs the latch
  assign arr_wr_ok = q.wel && !q.busy && !arr_hit && !exec;
  assign status_byte       = q.stat_word;
  assign write_busy        = q.busy;
  assign hw_protect_active = q.hpe && !q.wp_lvl;
  assign lk.stat_tgl       = q.stat_tgl;
  assign lk.stat_word      = q.stat_word;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_cmd(logic [7:0] o);
    exec && !q.busy && opc == o;
  endsequence

  sequence s_cycle_starts;
    !q.busy ##1 q.busy;
  endsequence

  AST_SET_LATCH: assert property (
    s_cmd(OP_SET_LATCH) |=> q.wel)
    else $error("set-latch command left latch clear");

  AST_CLR_LATCH: assert property (
    s_cmd(OP_CLR_LATCH) |=> !q.wel)
    else $error("clear-latch command left latch set");

  AST_WRITE_NEEDS_LATCH: assert property (
    s_cycle_starts |-> $past(q.wel))
    else $error("write cycle began with latch clear");

  AST_HW_PROT_REFUSE: assert property (
    (s_cmd(OP_WR_STATUS) ##0 (q.hpe && !q.wp_lvl)) |=> !q.busy)
    else $error("status write taken under hardware protection");

  AST_BUSY_IGNORES: assert property (
    (exec && q.busy && q.timer != '0) |=> $stable(q.wel) && $stable(q.bp))
    else $error("command acted during write cycle");

  AST_STATUS_DEFERRED: assert property (
    (q.busy && q.timer != '0) |=> $stable(q.bp) && $stable(q.hpe))
    else $error("status fields changed before write completed");

  AST_WEL_AFTER_WRITE: assert property (
    $fell(q.busy) |-> !q.wel)
    else $error("latch still set after write completed");

  AST_BUSY_BYTE: assert property (
    (q.stat_word[6:4] != 3'b000) |-> q.stat_word == STATUS_BUSY)
    else $error("unstored bits high outside write cycle");

  AST_BLOCK_KEPT: assert property (
    (arr_wr_req && !q.busy && !exec && in_block(q.bp, arr_wr_addr))
      |=> !q.busy)
    else $error("write started inside protected block");

  AST_WRITE_LENGTH: assert property (
    s_cycle_starts |-> q.timer == TMR_LOAD && stat_now == STATUS_BUSY)
    else $error("write cycle loaded wrong length");

endmodule : spp_status_protect

//--- spp_host_model.sv
// spp_host_model: serial host on the far side of the status/protect core.
// Assumes mode 0 framing; sck idles low and runs only inside frames.
`timescale 1ns/100ps
module spp_host_model (
  // serial pins toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  // serial pins from the device
  input  wire logic so,
  input  wire logic so_oe
);
  localparam realtime HALF = 7.5;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // ****************************************
  // bit and frame primitives
  // ****************************************
  task automatic bit_x(input logic b, output logic r);
    si = b;
    #HALF;
    // released data line reads as the inverse of what was driven
    r = so_oe ? so : ~so;
    sck = 1'b1;
    #HALF;
    sck = 1'b0;
  endtask : bit_x

  // pause mid-frame; sck pulses meant to be ignored
  task automatic suspend();
    #HALF;
    hold_n = 1'b0;
    repeat (3) begin
      si = ~si;
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
    #HALF;
    hold_n = 1'b1;
    #HALF;
  endtask : suspend

  task automatic open_frame();
    cs_n = 1'b0;
    #HALF;
  endtask : open_frame

  // released data line shows the inverse of its last value
  task automatic close_frame();
    #HALF;
    cs_n = 1'b1;
    si = ~si;
    #80;
  endtask : close_frame

  // opcode-only frame, optional suspend before bit hold_at
  task automatic cmd8(input logic [7:0] op, input int hold_at);
    logic r;
    open_frame();
    for (int i = 0; i < 8; i++) begin
      if (i == hold_at) suspend();
      bit_x(op[7-i], r);
    end
    close_frame();
  endtask : cmd8

  task automatic cmd16(input logic [15:0] tx, output logic [15:0] rx);
    open_frame();
    for (int i = 0; i < 16; i++) bit_x(tx[15-i], rx[15-i]);
    close_frame();
  endtask : cmd16
endmodule : spp_host_model

//--- spp_status_protect_tb.sv
// spp_status_protect_tb: self-checking bench for the status/protect core.
// Assumes spp_host_model stands in for the serial host.
`timescale 1ns/100ps
module spp_status_protect_tb;
  import spp_pkg::*;
  localparam int WCYC = 200;
  logic       clock, resetn, sck, cs_n, si, hold_n, so, so_oe;
  logic       wp_n, arr_wr_req, arr_wr_ok, write_busy, hw_protect_active;
  logic [7:0] arr_wr_addr, status_byte, s;
  int         fails, checked;

  spp_status_protect #(.WRITE_CYCLES(WCYC)) uut (.clock(clock),
    .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so(so), .so_oe(so_oe), .wp_n(wp_n), .arr_wr_req(arr_wr_req),
    .arr_wr_addr(arr_wr_addr), .arr_wr_ok(arr_wr_ok),
    .status_byte(status_byte), .write_busy(write_busy),
    .hw_protect_active(hw_protect_active));
  spp_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so(so), .so_oe(so_oe));

  always #5 clock = ~clock;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  // second read gives the refreshed copy
  task automatic rd_status(output logic [7:0] v);
    logic [15:0] x;
    host.cmd16({OP_RD_STATUS, 8'h00}, x);
    host.cmd16({OP_RD_STATUS, 8'h00}, x);
    v = x[7:0];
  endtask : rd_status

  task automatic wait_idle();
    settle();
    // bounded wait after a write instead of polling status
    for (int i = 0; i < WCYC + 50; i++) begin
      if (write_busy !== 1'b1) break;
      @(posedge clock);
    end
    #1;
    check("write_busy idle", 8'h00, {7'h00, write_busy});
  endtask : wait_idle

  task automatic wr_status(input logic [7:0] v);
    logic [15:0] x;
    host.cmd8(OP_SET_LATCH, -1);
    host.cmd16({OP_WR_STATUS, v}, x);
    wait_idle();
  endtask : wr_status

  task automatic arr_try(input logic [7:0] a);
    @(posedge clock);
    arr_wr_req <= 1'b1;
    arr_wr_addr <= a;
    @(posedge clock);
    arr_wr_req <= 1'b0;
    @(posedge clock);
    #1;
  endtask : arr_try

  task automatic ok_at(input logic [7:0] a, input logic e);
    @(posedge clock);
    arr_wr_addr <= a;
    #1;
    check("arr_wr_ok", {7'h00, e}, {7'h00, arr_wr_ok});
  endtask : ok_at

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("status_byte", STATUS_RST, status_byte);
    check("write_busy", 8'h00, {7'h00, write_busy});
    rd_status(s);
    check("status read", 8'h00, s);
    $display("test reset done");
  endtask : t_reset

  task automatic t_latch();
    arr_try(8'h10);
    check("write_busy", 8'h00, {7'h00, write_busy});
    host.cmd8(8'h0E, -1);
    settle();
    ok_at(8'h10, 1'b1);
    rd_status(s);
    check("status read", 8'h02, s);
    host.cmd8(OP_CLR_LATCH, -1);
    settle();
    ok_at(8'h10, 1'b0);
    host.cmd8(OP_SET_LATCH, 4);
    settle();
    ok_at(8'h10, 1'b1);
    $display("test latch done");
  endtask : t_latch

  task automatic t_write();
    logic [15:0] x;
    arr_try(8'h10);
    check("write_busy", 8'h01, {7'h00, write_busy});
    rd_status(s);
    check("busy read", STATUS_BUSY, s);
    // published copy follows once the link has acknowledged
    check("status_byte", STATUS_BUSY, status_byte);
    // status write with the latch set must be ignored while busy
    host.cmd16({OP_WR_STATUS, 8'h8C}, x);
    wait_idle();
    ok_at(8'h10, 1'b0);
    rd_status(s);
    check("status read", 8'h00, s);
    $display("test write done");
  endtask : t_write

  task automatic t_levels();
    logic [7:0] lo[3] = '{8'hBF, 8'h7F, 8'h00};
    logic [7:0] hi[3] = '{8'hC0, 8'h80, 8'hFF};
    for (int lv = 1; lv < 4; lv++) begin
      wr_status(8'h70 | 8'(lv << 2));
      rd_status(s);
      check("level read", 8'(lv << 2), s);
      host.cmd8(OP_SET_LATCH, -1);
      settle();
      ok_at(lo[lv-1], lv != 3);
      ok_at(hi[lv-1], 1'b0);
    end
    $display("test levels done");
  endtask : t_levels

  task automatic t_hwprot();
    wr_status(8'h80);
    wp_n <= 1'b0;
    settle();
    check("hw_protect", 8'h01, {7'h00, hw_protect_active});
    wr_status(8'h00);
    rd_status(s);
    check("refused write", 8'h82, s);
    ok_at(8'hFF, 1'b1);
    wp_n <= 1'b1;
    settle();
    check("hw_protect", 8'h00, {7'h00, hw_protect_active});
    wr_status(8'h00);
    rd_status(s);
    check("status read", 8'h00, s);
    $display("test hwprot done");
  endtask : t_hwprot

  task automatic t_rst_mid();
    wr_status(8'h84);
    host.cmd8(OP_SET_LATCH, -1);
    settle();
    ok_at(8'h10, 1'b1);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    settle();
    check("status_byte", STATUS_RST, status_byte);
    ok_at(8'h10, 1'b0);
    rd_status(s);
    check("status read", 8'h00, s);
    $display("test mid-run reset done");
  endtask : t_rst_mid

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    wp_n = 1'b1;
    arr_wr_req = 1'b0;
    arr_wr_addr = 8'h00;
    fails = 0;
    checked = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    settle();
    t_reset();
    t_latch();
    t_write();
    t_levels();
    t_hwprot();
    t_rst_mid();
    conclude();
  end

  initial begin
    #300us;
    fails++;
    conclude();
  end
endmodule : spp_status_protect_tb
